//--- inc/ispc_pkg.sv
// Constants and types shared by the idle/stop power control block.
package ispc_pkg;
  localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
  localparam int PWR_CTRL_IDLE_BIT = 0;
  localparam int PWR_CTRL_STOP_BIT = 1;
  localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int MISCLK_TIMEOUT_US = 100;
  localparam int MISCLK_TIMEOUT_CYC = (MISCLK_TIMEOUT_US * CLK_FREQ_KHZ) / 1000;
  localparam int RESET_EXIT_CYC = 12;
  localparam int PIN_SYNC_RESET = 1;
  typedef enum logic [1:0] {
    ISPC_RUN,
    ISPC_IDLE,
    ISPC_STOP,
    ISPC_RESET
  } ispc_mode_t;
endpackage

//--- inc/ispc_wake_if.sv
// Interface between the power mode controller and its wake-source module.
`timescale 1ns/10ps
`default_nettype none
interface ispc_wake_if (
  input wire logic clk
);
  logic stop_active;
  logic misclk_enable;
  logic pin_rst;
  logic misclk_fire;
  modport ctrl (
    input clk,
    output stop_active,
    output misclk_enable,
    input pin_rst,
    input misclk_fire
  );
  modport wake (
    input clk,
    input stop_active,
    input misclk_enable,
    output pin_rst,
    output misclk_fire
  );
endinterface
`default_nettype wire

//--- rtl/ispc_wake.sv
// Wake sources: reset pin synchroniser and missing-clock timeout.
`timescale 1ns/10ps
`default_nettype none
module ispc_wake #(
  parameter int MISCLK_CYC = ispc_pkg::MISCLK_TIMEOUT_CYC
) (
  input wire logic sys_rst,
  input wire logic rst_pin_n,
  ispc_wake_if.wake wif
);
  localparam int CW = $clog2(MISCLK_CYC + 1);

  if (MISCLK_CYC < 2) begin : g_bad_misclk
    $error("MISCLK_CYC must be at least 2");
  end

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pin_lvl_n;
    logic [CW-1:0] misclk_cnt;
    logic misclk_fire;
  } ispc_wake_state_t;

  ispc_wake_state_t st_q;
  ispc_wake_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = rst_pin_n;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // A change counts only once the second and third stages agree.
    if (st_q.s2 == st_q.s3) begin
      st_d.pin_lvl_n = st_q.s3;
    end
    st_d.misclk_fire = 1'b0;
    // The count runs on this same clock; a truly stopped oscillator would need a
    // free-running reference here instead.
    if (wif.stop_active && wif.misclk_enable) begin // R13
      if (st_q.misclk_cnt == CW'(MISCLK_CYC - 1)) begin
        st_d.misclk_fire = 1'b1;
        st_d.misclk_cnt = '0;
      end else begin
        st_d.misclk_cnt = st_q.misclk_cnt + CW'(1);
      end
    end else begin
      st_d.misclk_cnt = '0;
    end
  end

  always_ff @(posedge wif.clk) begin
    if (sys_rst) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, pin_lvl_n: 1'b1, misclk_cnt: '0,
                misclk_fire: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign wif.pin_rst = ~st_q.pin_lvl_n;
  assign wif.misclk_fire = st_q.misclk_fire;

  a_misclk_timeout: assert property (@(posedge wif.clk) disable iff (sys_rst) // R13
    $rose(st_q.misclk_fire) |-> $past(wif.stop_active) && $past(wif.misclk_enable))
    else $error("missing-clock reset without enabled stop");
endmodule // ispc_wake
`default_nettype wire

//--- rtl/ispc_top.sv
// Idle and stop power mode controller with its power control register.
//
// Contract
// R1: Idle begins only after writing instruction completes.
// R2: Idle keeps state, peripherals keep running.
// R3: Enabled interrupt or reset pin ends idle.
// R4: Interrupt wake clears idle, restarts, services interrupt.
// R5: After return, resume after idle-setting instruction.
// R6: Reset ends idle, reset sequence, fetch 0x0000.
// R7: Watchdog runs in idle; overflow resets device.
// R8: Software disables unlocked watchdog for endless idle.
// R9: Follow idle-setting instruction with two-byte opcode.
// R10: Stop halts processor and oscillator after instruction.
// R11: In stop only missing-clock detector stays active.
// R12: Only reset ends stop; fetch from 0x0000.
// R13: Missing-clock detector resets; disable for long stops.
// R14: Mode bits read zero; zero writes ignored.
// R15: Both bits written together: stop wins.
`timescale 1ns/10ps
`default_nettype none
module ispc_top #(
  parameter int HOLD_CYC = ispc_pkg::RESET_EXIT_CYC,
  parameter int MISCLK_CYC = ispc_pkg::MISCLK_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rst_pin_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic insn_done,
  input wire logic irq_pend,
  input wire logic watchdog_overflow,
  input wire logic int_rst_req,
  input wire logic misclk_enable,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic irq_timer_en,
  output logic watchdog_clk_en,
  output logic core_rst,
  output logic [15:0] fetch_vector,
  output logic irq_resume,
  output logic idle_active,
  output logic stop_active
);
  localparam int HW = $clog2(HOLD_CYC + 1);

  if (HOLD_CYC < 1) begin : g_bad_hold
    $error("HOLD_CYC must be at least 1");
  end

  typedef struct packed {
    ispc_pkg::ispc_mode_t mode;
    logic arm_idle;
    logic arm_stop;
    logic [HW-1:0] hold;
    logic irq_resume;
    logic [7:0] rdata;
    logic [15:0] vector;
  } ispc_state_t;

  ispc_state_t st_q;
  ispc_state_t st_d;

  ispc_wake_if wif (
    .clk(clk)
  );

  ispc_wake #(
    .MISCLK_CYC(MISCLK_CYC)
  ) u_wake (
    .sys_rst(sys_rst),
    .rst_pin_n(rst_pin_n),
    .wif(wif)
  );

  logic wr_hit;
  logic rst_any;
  logic arm_i;
  logic arm_s;

  assign wif.stop_active = (st_q.mode == ispc_pkg::ISPC_STOP);
  assign wif.misclk_enable = misclk_enable;

  assign wr_hit = sfr_wr && (sfr_addr == ispc_pkg::PWR_CTRL_ADDR);
  assign sfr_hit = (sfr_wr || sfr_rd) && (sfr_addr == ispc_pkg::PWR_CTRL_ADDR);

  // Any internal or external reset source ends whatever mode is active.
  assign rst_any = wif.pin_rst | watchdog_overflow | int_rst_req | wif.misclk_fire; // R3 R6 R7 R12 R13

  // Writing zero leaves an earlier request armed.
  assign arm_i = st_q.arm_idle | (wr_hit & sfr_wdata[ispc_pkg::PWR_CTRL_IDLE_BIT]); // R14
  assign arm_s = st_q.arm_stop | (wr_hit & sfr_wdata[ispc_pkg::PWR_CTRL_STOP_BIT]); // R14

  always_comb begin
    st_d = st_q;
    st_d.irq_resume = 1'b0;
    // Both mode bits are write-only, so every read returns zero.
    st_d.rdata = ispc_pkg::PWR_CTRL_RESET; // R14
    if (rst_any) begin
      st_d.mode = ispc_pkg::ISPC_RESET; // R6 R12
      st_d.hold = '0;
      st_d.arm_idle = 1'b0;
      st_d.arm_stop = 1'b0;
    end else begin
      case (st_q.mode)
        ispc_pkg::ISPC_RUN: begin
          // The halt waits for the writing instruction to retire.
          if (insn_done) begin // R1 R10
            if (arm_s) begin
              st_d.mode = ispc_pkg::ISPC_STOP; // R15
            end else if (arm_i) begin
              st_d.mode = ispc_pkg::ISPC_IDLE; // R1
            end
            st_d.arm_idle = 1'b0;
            st_d.arm_stop = 1'b0;
          end else begin
            st_d.arm_idle = arm_i;
            st_d.arm_stop = arm_s;
          end
        end
        ispc_pkg::ISPC_IDLE: begin
          // The core reset is not touched, so the program counter still points
          // past the idle-setting instruction when the handler returns.
          if (irq_pend) begin // R3 R4 R5
            st_d.mode = ispc_pkg::ISPC_RUN;
            st_d.irq_resume = 1'b1;
          end
        end
        ispc_pkg::ISPC_STOP: begin
          // Interrupts cannot end stop; only the reset path above can.
          st_d.mode = ispc_pkg::ISPC_STOP; // R12
        end
        ispc_pkg::ISPC_RESET: begin
          if (st_q.hold == HW'(HOLD_CYC - 1)) begin // R6
            st_d.mode = ispc_pkg::ISPC_RUN;
            st_d.hold = '0;
          end else begin
            st_d.hold = st_q.hold + HW'(1);
          end
          st_d.vector = ispc_pkg::RESET_VECTOR; // R6 R12
        end
        default: begin
          st_d.mode = ispc_pkg::ISPC_RESET;
          st_d.hold = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '{mode: ispc_pkg::ISPC_RESET, arm_idle: 1'b0, arm_stop: 1'b0, hold: '0,
                irq_resume: 1'b0, rdata: ispc_pkg::PWR_CTRL_RESET,
                vector: ispc_pkg::RESET_VECTOR};
    end else begin
      st_q <= st_d;
    end
  end

  assign idle_active = (st_q.mode == ispc_pkg::ISPC_IDLE);
  assign stop_active = (st_q.mode == ispc_pkg::ISPC_STOP);
  assign core_rst = (st_q.mode == ispc_pkg::ISPC_RESET);
  // Only the processor clock is gated in idle; registers simply hold.
  assign cpu_clk_en = (st_q.mode == ispc_pkg::ISPC_RUN); // R1 R2
  assign periph_clk_en = !stop_active; // R2 R10
  assign osc_en = !stop_active; // R10
  assign irq_timer_en = !stop_active; // R11
  // A watchdog that software left enabled keeps counting through idle.
  assign watchdog_clk_en = !stop_active; // R7
  assign irq_resume = st_q.irq_resume;
  assign sfr_rdata = st_q.rdata;
  assign fetch_vector = st_q.vector;

  a_idle_after_done: assert property (@(posedge clk) disable iff (sys_rst) // R1
    $rose(idle_active) |-> $past(insn_done) && $past(st_q.mode) == ispc_pkg::ISPC_RUN)
    else $error("idle entered before instruction completed");

  a_idle_entry: assert property (@(posedge clk) disable iff (sys_rst) // R1
    (cpu_clk_en && wr_hit && sfr_wdata == 8'h01 && insn_done && !rst_any)
      |=> idle_active && !cpu_clk_en)
    else $error("idle write did not halt processor");

  a_idle_keeps_run: assert property (@(posedge clk) disable iff (sys_rst) // R2
    idle_active |-> periph_clk_en && osc_en && irq_timer_en && !cpu_clk_en)
    else $error("peripherals not running during idle");

  a_idle_irq_wake: assert property (@(posedge clk) disable iff (sys_rst) // R4
    (idle_active && irq_pend && !rst_any) |=> cpu_clk_en && irq_resume ##1 !irq_resume)
    else $error("interrupt did not wake from idle");

  a_idle_watchdog_run: assert property (@(posedge clk) disable iff (sys_rst) // R7
    (idle_active && watchdog_overflow) |-> watchdog_clk_en ##1 core_rst && !idle_active)
    else $error("watchdog overflow did not end idle");

  a_stop_prio: assert property (@(posedge clk) disable iff (sys_rst) // R15
    (cpu_clk_en && wr_hit && sfr_wdata == 8'h03 && insn_done && !rst_any) |=> stop_active)
    else $error("stop did not take precedence over idle");

  a_stop_gates: assert property (@(posedge clk) disable iff (sys_rst) // R11
    stop_active |-> !osc_en && !irq_timer_en && !cpu_clk_en && !watchdog_clk_en)
    else $error("clock or interrupt left active in stop");

  a_stop_only_rst: assert property (@(posedge clk) disable iff (sys_rst) // R12
    (stop_active && !rst_any) |=> stop_active)
    else $error("stop left without reset");

  a_reset_exit: assert property (@(posedge clk) disable iff (sys_rst) // R6
    $fell(core_rst) |-> $past(core_rst, 12) && fetch_vector == 16'h0000)
    else $error("reset sequence too short or wrong vector");

  a_read_zero: assert property (@(posedge clk) disable iff (sys_rst) // R14
    (sfr_rd && sfr_hit) |=> sfr_rdata == 8'h00)
    else $error("power control register read nonzero");

  a_misclk_ends_stop: assert property (@(posedge clk) disable iff (sys_rst) // R13
    (stop_active && wif.misclk_fire) |=> core_rst && !stop_active)
    else $error("missing-clock reset did not end stop");

  a_stop_periph_off: assert property (@(posedge clk) disable iff (sys_rst) // R10
    stop_active |-> !periph_clk_en)
    else $error("peripheral clock running in stop");

  // An interrupt must never restart a stopped core; only reset may.
  a_stop_irq_ignored: assert property (@(posedge clk) disable iff (sys_rst) // R11
    (stop_active && irq_pend && !rst_any) |=> !irq_resume && !cpu_clk_en)
    else $error("interrupt woke core from stop");

  a_reset_vector: assert property (@(posedge clk) disable iff (sys_rst) // R6
    core_rst |-> fetch_vector == ispc_pkg::RESET_VECTOR)
    else $error("reset sequence without reset vector");

  a_resume_single: assert property (@(posedge clk) disable iff (sys_rst) // R4
    irq_resume |=> !irq_resume)
    else $error("interrupt resume pulse longer than one cycle");

  a_zero_write_ignored: assert property (@(posedge clk) disable iff (sys_rst) // R14
    (cpu_clk_en && wr_hit && sfr_wdata[1:0] == 2'b00 && !st_q.arm_idle && !st_q.arm_stop
      && !rst_any) |=> cpu_clk_en)
    else $error("zero write changed power mode");
endmodule // ispc_top
`default_nettype wire

//--- verif/ispc_core_model.sv
// Behavioural processor core that retires an instruction every few cycles while clocked.
`timescale 1ns/10ps
`default_nettype none
module ispc_core_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cpu_clk_en,
  input wire logic slow,
  output logic insn_done
);
  int cnt = 0;
  initial insn_done = 1'b0;
  // Each instruction takes two cycles or more, so no single-byte follower ever occurs.
  always @(posedge clk) begin
    if (sys_rst || !cpu_clk_en) begin
      cnt <= 0;
      insn_done <= 1'b0;
    end else begin
      cnt <= (cnt >= (slow ? 4 : 1)) ? 0 : cnt + 1;
      insn_done <= (cnt >= (slow ? 4 : 1));
    end
  end
endmodule // ispc_core_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the idle and stop power control block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
  localparam int HOLD = 12;
  localparam int MISCLK = 16;
  logic clk = 0, sys_rst = 1, rst_pin_n = 1, sfr_wr = 0, sfr_rd = 0, insn_done, slow = 0;
  logic irq_pend = 0, watchdog_overflow = 0, int_rst_req = 0, misclk_enable = 0, m_resume = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic sfr_hit, cpu_clk_en, periph_clk_en, osc_en, irq_timer_en, watchdog_clk_en, core_rst;
  logic irq_resume, idle_active, stop_active, src;
  logic [15:0] fetch_vector;
  // Four stages: three synchroniser flops plus the accepted level register.
  logic [3:0] m_pin = 4'b1111;
  logic [1:0] wb;
  int fail_count = 0, num_checks = 0, seed = 59, r, n, m_mode = 3, m_hold = HOLD;
  int m_arm = 0, m_misclk = 0;
  always #12.5 clk = ~clk;
  ispc_top #(.HOLD_CYC(HOLD), .MISCLK_CYC(MISCLK)) i_dut (.clk, .sys_rst, .rst_pin_n,
    .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit, .insn_done, .irq_pend,
    .watchdog_overflow, .int_rst_req, .misclk_enable, .cpu_clk_en, .periph_clk_en, .osc_en,
    .irq_timer_en, .watchdog_clk_en, .core_rst, .fetch_vector, .irq_resume, .idle_active,
    .stop_active);
  ispc_core_model i_core (.clk, .sys_rst, .cpu_clk_en, .slow, .insn_done);
  // Mode model: 0 run, 1 idle, 2 stop, 3 reset sequence.
  always @(posedge clk) begin
    src = sys_rst | watchdog_overflow | int_rst_req | !m_pin[3] | (m_misclk > MISCLK);
    m_pin = {m_pin[2:0], rst_pin_n};
    m_resume = 0;
    wb = (sfr_wr && sfr_addr == 8'h87 && m_mode == 0) ? sfr_wdata[1:0] : 2'b00;
    if (src) begin
      m_mode = 3;
      m_hold = HOLD;
      m_arm = 0;
    end else if (m_mode == 3) begin
      if (m_hold > 1) m_hold--;
      else m_mode = 0;
    end else if (m_mode == 1 && irq_pend) begin
      m_mode = 0;
      m_resume = 1;
    end else if (m_mode == 0 && insn_done && (m_arm | wb) != 0) begin
      m_mode = ((m_arm | wb) & 2) ? 2 : 1;
      m_arm = 0;
    end else m_arm = m_arm | wb;
    m_misclk = (m_mode == 2 && misclk_enable) ? m_misclk + 1 : 0;
  end
  task tally_and_finish;
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk_all;
    `CHK("idle_active", m_mode == 1, idle_active)
    `CHK("stop_active", m_mode == 2, stop_active)
    `CHK("cpu_clk_en", m_mode == 0, cpu_clk_en)
    `CHK("periph_clk_en", m_mode != 2, periph_clk_en)
    `CHK("osc_en", m_mode != 2, osc_en)
    `CHK("irq_timer_en", m_mode != 2, irq_timer_en)
    `CHK("watchdog_clk_en", m_mode != 2, watchdog_clk_en)
    `CHK("core_rst", m_mode == 3, core_rst)
    `CHK("irq_resume", m_resume, irq_resume)
  endtask
  task run_chk(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
      chk_all;
    end
  endtask
  task acc(input logic [7:0] a, input logic [7:0] d, input logic rd);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= !rd;
    sfr_rd <= rd;
    #1;
    `CHK("sfr_hit", a == 8'h87, sfr_hit)
    @(posedge clk);
    sfr_wr <= 0;
    sfr_rd <= 0;
    #1;
    `CHK("sfr_rdata", 8'h00, sfr_rdata)
    chk_all;
  endtask
  task pulse_src(input int s);
    @(posedge clk);
    watchdog_overflow <= (s == 0);
    int_rst_req <= (s == 1);
    @(posedge clk);
    watchdog_overflow <= 0;
    int_rst_req <= 0;
    #1;
    chk_all;
    run_chk(HOLD + 2);
    `CHK("fetch_vector", 16'h0000, fetch_vector)
  endtask
  initial begin
    #(25 * 3000);
    fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 0;
    n = 0;
    while ((core_rst !== 1'b0 || m_mode != 0) && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    run_chk(2);
    r = $random(seed);
    acc(8'h87, 8'h00, 1);
    acc(8'h87, {r[7:2], 2'b00}, 0);
    acc(8'h87 ^ {r[7:1], 1'b1}, 8'h03, 0);
    run_chk(6);
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      acc(8'h87, 8'h01, 0);
      run_chk(8);
      @(posedge clk);
      irq_pend <= 1;
      @(posedge clk);
      irq_pend <= 0;
      #1;
      chk_all;
      run_chk(4);
    end
    for (int s = 0; s < 2; s++) begin
      acc(8'h87, 8'h01, 0);
      run_chk(8);
      pulse_src(s);
    end
    acc(8'h87, 8'h01, 0);
    run_chk(8);
    @(posedge clk);
    rst_pin_n <= 0;
    repeat (8) @(posedge clk);
    rst_pin_n <= 1;
    #1;
    `CHK("pin core_rst", 1'b1, core_rst)
    `CHK("pin idle", 1'b0, idle_active)
    // The wait covers the synchroniser release delay and the HOLD-cycle reset sequence before the compare.
    repeat (24) @(posedge clk);
    #1;
    chk_all;
    slow <= 0;
    acc(8'h87, 8'h03, 0);
    @(posedge clk);
    irq_pend <= 1;
    run_chk(10);
    @(posedge clk);
    irq_pend <= 0;
    misclk_enable <= 1;
    pulse_src(1);
    acc(8'h87, 8'h02, 0);
    n = 0;
    while (core_rst !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("misclk delay", 1'b1, n >= MISCLK - 2 && n <= MISCLK + 4)
    @(posedge clk);
    misclk_enable <= 0;
    repeat (20) @(posedge clk);
    #1;
    chk_all;
    acc(8'h87, 8'h02, 0);
    run_chk(MISCLK + 8);
    pulse_src(1);
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
